// >>> pfcuv_host_model.sv
// host model: issues one-cycle register requests the way the supply controller does
`timescale 1ns/100ps
module pfcuv_host_model
    import pfcuv_pkg::*;
(
    input wire logic clock,
    output pfcuv_req_t req
);
    // idle bus at time zero
    initial begin
        req = '0;
    end
    // one write strobe; fields inverted on release so stale values never look valid
    task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge clock);
        req = {1'b1, 1'b0, cmd, data};
        @(negedge clock);
        req = {1'b0, 1'b0, ~cmd, ~data};
    endtask : write_reg
    // one read strobe
    task automatic read_reg(input logic [7:0] cmd);
        @(negedge clock);
        req = {1'b0, 1'b1, cmd, 16'h0000};
        @(negedge clock);
        req = {1'b0, 1'b0, ~cmd, 16'hFFFF};
    endtask : read_reg
endmodule : pfcuv_host_model

// >>> pfcuv_limit_fault.sv
// output voltage limits, warnings and undervoltage fault sequencer
`timescale 1ns/100ps
module pfcuv_limit_fault
    import pfcuv_pkg::*;
#(
    parameter int MS_CYCLES = PFCUV_MS_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input pfcuv_req_t req,
    input wire logic [2:0] mode_exp,
    input wire logic [23:0] out_meas,
    output logic [15:0] rd_data_reg,
    output logic rd_valid_reg,
    output pfcuv_status_t status_reg
);

    logic [10:0] ov_warn_mant_reg; // overvoltage warning mantissa
    logic [10:0] uv_warn_mant_reg; // undervoltage warning mantissa
    logic [10:0] uv_fault_mant_reg; // undervoltage fault mantissa
    logic [7:0] action_reg; // undervoltage fault action
    logic [4:0] exp_field; // sign-extended exponent for readback
    logic [23:0] ov_thr; // scaled thresholds
    logic [23:0] uv_warn_thr;
    logic [23:0] uv_fault_thr;
    logic ov_now; // live compare results
    logic uv_warn_now;
    logic uv_now;
    pfcuv_resp_t resp; // selected reaction
    logic [2:0] retry_code; // retry field
    logic [2:0] dly_code; // delay field
    logic action_wr; // write hits the action register
    pfcuv_state_t state_reg; // sequencer state
    logic [2:0] retries_left_reg; // restarts still allowed
    logic tmr_start_reg; // timer start pulse
    logic [11:0] tmr_ms_reg; // timer length in ms
    logic tmr_done; // timer expiry pulse

    // exponent mirrors the mode register, sign extended to five bits
    assign exp_field = {{2{mode_exp[2]}}, mode_exp};

    // fields of the action register
    assign resp = pfcuv_resp_t'(action_reg[PFCUV_RESP_LSB +: 2]);
    assign retry_code = action_reg[PFCUV_RETRY_LSB +: 3];
    assign dly_code = action_reg[PFCUV_DLY_LSB +: 3];
    assign action_wr = req.wr && (req.cmd == PFCUV_CMD_ACTION);

    // thresholds are mantissa times two to the exponent
    assign ov_thr = pfcuv_scale(ov_warn_mant_reg, mode_exp);
    assign uv_warn_thr = pfcuv_scale(uv_warn_mant_reg, mode_exp);
    assign uv_fault_thr = pfcuv_scale(uv_fault_mant_reg, mode_exp);

    // limit compares
    assign ov_now = out_meas > ov_thr;
    assign uv_warn_now = out_meas < uv_warn_thr;
    assign uv_now = out_meas < uv_fault_thr;

    // register writes; exponent bits of a write are dropped
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ov_warn_mant_reg <= PFCUV_OV_WARN_RST;
            uv_warn_mant_reg <= PFCUV_UV_WARN_RST;
            uv_fault_mant_reg <= PFCUV_UV_FAULT_RST;
            action_reg <= PFCUV_ACTION_RST;
        end else if (req.wr) begin
            case (req.cmd)
                PFCUV_CMD_OV_WARN: ov_warn_mant_reg <= req.data[PFCUV_MANT_W-1:0];
                PFCUV_CMD_UV_WARN: uv_warn_mant_reg <= req.data[PFCUV_MANT_W-1:0];
                PFCUV_CMD_UV_FAULT: uv_fault_mant_reg <= req.data[PFCUV_MANT_W-1:0];
                PFCUV_CMD_ACTION: action_reg <= req.data[7:0];
                default: ; // other codes belong elsewhere
            endcase
        end
    end

    // register reads, answered one cycle later; unknown codes read zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= req.rd;
            if (req.rd) begin
                case (req.cmd)
                    PFCUV_CMD_OV_WARN: rd_data_reg <= {exp_field, ov_warn_mant_reg};
                    PFCUV_CMD_UV_WARN: rd_data_reg <= {exp_field, uv_warn_mant_reg};
                    PFCUV_CMD_UV_FAULT: rd_data_reg <= {exp_field, uv_fault_mant_reg};
                    PFCUV_CMD_ACTION: rd_data_reg <= {8'h00, action_reg};
                    default: rd_data_reg <= 16'h0000;
                endcase
            end
        end
    end

    // warning and fault flags follow the compares
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_reg.ov_warn <= 1'b0;
            status_reg.uv_warn <= 1'b0;
            status_reg.uv_fault <= 1'b0;
        end else begin
            status_reg.ov_warn <= ov_now;
            status_reg.uv_warn <= uv_warn_now;
            status_reg.uv_fault <= uv_now;
        end
    end

    // delay timer shared by both delays
    pfcuv_ms_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .clock(clock),
        .rstn(rstn),
        .start(tmr_start_reg),
        .target_ms(tmr_ms_reg),
        .done_reg(tmr_done)
    );

    // fault sequencer: output enable, retries and delays
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= PFCUV_ST_RUN;
            retries_left_reg <= 3'h0;
            tmr_start_reg <= 1'b0;
            tmr_ms_reg <= 12'h000;
            status_reg.out_enable <= 1'b1;
            status_reg.latched_off <= 1'b0;
        end else begin
            tmr_start_reg <= 1'b0;
            case (state_reg)
                // normal running; retry budget tracks the setting
                PFCUV_ST_RUN: begin
                    retries_left_reg <= retry_code;
                    status_reg.out_enable <= 1'b1;
                    if (uv_now) begin
                        case (resp)
                            PFCUV_RESP_DELAY: begin
                                state_reg <= PFCUV_ST_WAIT_D1;
                                tmr_start_reg <= 1'b1;
                                tmr_ms_reg <= pfcuv_dly1_ms(dly_code);
                            end
                            PFCUV_RESP_RESTART: begin
                                status_reg.out_enable <= 1'b0;
                                if (retry_code == 3'h0) begin
                                    state_reg <= PFCUV_ST_LATCHED;
                                    status_reg.latched_off <= 1'b1;
                                end else begin
                                    state_reg <= PFCUV_ST_OFF_WAIT;
                                    tmr_start_reg <= 1'b1;
                                    tmr_ms_reg <= pfcuv_dly2_ms(dly_code);
                                end
                            end
                            PFCUV_RESP_HOLD: begin
                                state_reg <= PFCUV_ST_HOLD;
                                status_reg.out_enable <= 1'b0;
                            end
                            default: ; // ignore: keep running
                        endcase
                    end
                end
                // first delay with output still on
                PFCUV_ST_WAIT_D1: begin
                    retries_left_reg <= retry_code;
                    if (tmr_done) begin
                        if (!uv_now) begin
                            state_reg <= PFCUV_ST_RUN; // fault went away
                        end else if (retry_code == 3'h0) begin
                            state_reg <= PFCUV_ST_LATCHED;
                            status_reg.out_enable <= 1'b0;
                            status_reg.latched_off <= 1'b1;
                        end else begin
                            state_reg <= PFCUV_ST_OFF_WAIT;
                            status_reg.out_enable <= 1'b0;
                            tmr_start_reg <= 1'b1;
                            tmr_ms_reg <= pfcuv_dly2_ms(dly_code);
                        end
                    end
                end
                // output off, spacing before the next restart
                PFCUV_ST_OFF_WAIT: begin
                    if (tmr_done) begin
                        state_reg <= PFCUV_ST_SETTLE;
                        status_reg.out_enable <= 1'b1;
                        if (retries_left_reg != PFCUV_RETRY_INF) begin
                            retries_left_reg <= retries_left_reg - 3'h1;
                        end
                        tmr_start_reg <= 1'b1;
                        tmr_ms_reg <= pfcuv_dly1_ms(dly_code);
                    end
                end
                // restarted; give the output time to rise before judging
                PFCUV_ST_SETTLE: begin
                    if (tmr_done) begin
                        if (!uv_now) begin
                            state_reg <= PFCUV_ST_RUN;
                        end else if (retries_left_reg == 3'h0) begin
                            state_reg <= PFCUV_ST_LATCHED;
                            status_reg.out_enable <= 1'b0;
                            status_reg.latched_off <= 1'b1;
                        end else begin
                            state_reg <= PFCUV_ST_OFF_WAIT;
                            status_reg.out_enable <= 1'b0;
                            tmr_start_reg <= 1'b1;
                            tmr_ms_reg <= pfcuv_dly2_ms(dly_code);
                        end
                    end
                end
                // off while the fault lasts, back on once clear
                PFCUV_ST_HOLD: begin
                    if (!uv_now) begin
                        state_reg <= PFCUV_ST_RUN;
                        status_reg.out_enable <= 1'b1;
                    end
                end
                // retries used up; a write to the action register re-arms
                PFCUV_ST_LATCHED: begin
                    if (action_wr) begin
                        state_reg <= PFCUV_ST_RUN;
                        status_reg.out_enable <= 1'b1;
                        status_reg.latched_off <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= PFCUV_ST_RUN;
                    status_reg.out_enable <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // flags and exponent mirror

    a_ov_warn_flag: assert property (ov_now |=> status_reg.ov_warn)
        else $error("overvoltage warning missed");
    a_uv_warn_flag: assert property (status_reg.uv_warn == $past(uv_warn_now))
        else $error("undervoltage warning wrong");
    a_uv_fault_flag: assert property ((out_meas < uv_fault_thr) |=> status_reg.uv_fault)
        else $error("undervoltage fault missed");
    a_exp_readback: assert property (req.rd && req.cmd == PFCUV_CMD_UV_FAULT |=>
        rd_valid_reg && rd_data_reg[15:11] == {{2{$past(mode_exp[2])}}, $past(mode_exp)})
        else $error("exponent readback wrong");
    a_exp_sign: assert property (rd_valid_reg && rd_data_reg[13] |-> rd_data_reg[15:14] == 2'b11
        || $past(req.cmd) == PFCUV_CMD_ACTION || $past(req.cmd) > PFCUV_CMD_ACTION
        || $past(req.cmd) < PFCUV_CMD_OV_WARN)
        else $error("exponent not sign extended");

    // register port: answers and mantissa storage
    a_mant_write: assert property (req.wr && req.cmd == PFCUV_CMD_OV_WARN ##1 !req.wr ##1 req.rd
        && req.cmd == PFCUV_CMD_OV_WARN |=> rd_data_reg[10:0] == $past(req.data[10:0], 3))
        else $error("mantissa write lost");
    a_read_answer: assert property (rd_valid_reg == $past(req.rd))
        else $error("read answer missing or extra");
    a_action_read: assert property (req.rd && req.cmd == PFCUV_CMD_ACTION
        |=> rd_data_reg == {8'h00, $past(action_reg)})
        else $error("action register readback wrong");

    // sequencer: reactions to the undervoltage fault
    a_ignore_stays_on: assert property (state_reg == PFCUV_ST_RUN && resp == PFCUV_RESP_IGNORE
        |=> status_reg.out_enable)
        else $error("ignore response changed output");
    a_delay_keeps_on: assert property (state_reg == PFCUV_ST_RUN && uv_now
        && resp == PFCUV_RESP_DELAY |=> state_reg == PFCUV_ST_WAIT_D1 && status_reg.out_enable
        ##1 tmr_ms_reg == PFCUV_DLY1_BASE_MS << dly_code)
        else $error("first delay not started");
    a_wait_d1_on: assert property (state_reg == PFCUV_ST_WAIT_D1 && !tmr_done
        |=> status_reg.out_enable)
        else $error("output dropped before first delay");
    a_shutdown_now: assert property (state_reg == PFCUV_ST_RUN && uv_now
        && resp == PFCUV_RESP_RESTART |=> !status_reg.out_enable)
        else $error("shutdown not immediate");
    a_hold_entry: assert property (state_reg == PFCUV_ST_RUN && uv_now
        && resp == PFCUV_RESP_HOLD |=> state_reg == PFCUV_ST_HOLD && !status_reg.out_enable)
        else $error("hold not entered");
    a_hold_release: assert property (state_reg == PFCUV_ST_HOLD && !uv_now
        |=> status_reg.out_enable && state_reg == PFCUV_ST_RUN)
        else $error("hold did not release");
    a_hold_off: assert property (state_reg == PFCUV_ST_HOLD && uv_now |=> !status_reg.out_enable)
        else $error("output on during hold");
    a_retry_spacing: assert property (state_reg == PFCUV_ST_OFF_WAIT && !tmr_done
        |=> state_reg == PFCUV_ST_OFF_WAIT && !status_reg.out_enable)
        else $error("restart before second delay");
    a_retry_unlimited: assert property (state_reg == PFCUV_ST_SETTLE
        && retries_left_reg == PFCUV_RETRY_INF |=> state_reg != PFCUV_ST_LATCHED)
        else $error("unlimited retries latched off");
    a_retry_no_count: assert property (state_reg == PFCUV_ST_OFF_WAIT && tmr_done
        && retries_left_reg == PFCUV_RETRY_INF |=> retries_left_reg == PFCUV_RETRY_INF)
        else $error("unlimited retry budget counted down");
    a_last_retry: assert property (state_reg == PFCUV_ST_SETTLE && tmr_done && uv_now
        && retries_left_reg == 3'h0 |=> status_reg.latched_off && !status_reg.out_enable)
        else $error("exhausted retries did not latch off");
    a_latched_stays: assert property (state_reg == PFCUV_ST_LATCHED && !action_wr
        |=> status_reg.latched_off && !status_reg.out_enable)
        else $error("latched off released early");

    // scenarios worth seeing
    c_delay_path: cover property (state_reg == PFCUV_ST_WAIT_D1 && tmr_done);
    c_restart_path: cover property (state_reg == PFCUV_ST_OFF_WAIT ##1 state_reg == PFCUV_ST_SETTLE);
    c_hold_path: cover property (state_reg == PFCUV_ST_HOLD ##1 state_reg == PFCUV_ST_RUN);
    c_latched: cover property (status_reg.latched_off);
    c_ov_warn: cover property (status_reg.ov_warn ##1 !status_reg.ov_warn);

endmodule : pfcuv_limit_fault

// >>> pfcuv_limit_fault_tb_top.sv
// testbench: limit registers, warning flags and undervoltage fault reactions
`timescale 1ns/100ps
module pfcuv_limit_fault_tb_top import pfcuv_pkg::*;;
    localparam int MSC = 4; // cycles per ms, shortened
    localparam logic [23:0] OK_V = 24'h020000; // healthy output
    localparam logic [23:0] BAD_V = 24'h004000; // below fault limit
    // table rows: mode exponent, measurement, expected {ov, uv warn, uv fault}
    localparam logic [29:0] WTAB [8] = '{{3'h0, 24'h030001, 3'h4}, {3'h0, 24'h030000, 3'h0},
        {3'h0, 24'h00FFFF, 3'h2}, {3'h0, 24'h010000, 3'h0}, {3'h0, 24'h007FFF, 3'h3},
        {3'h0, 24'h008000, 3'h2}, {3'h7, 24'h018001, 3'h4}, {3'h1, 24'h060001, 3'h4}};
    localparam logic [7:0] RTAB [3] = '{8'h80, 8'h88, 8'hB8}; // restart actions, retry 0, 1, 7
    logic clock; // system clock
    logic rstn; // active low reset
    logic [2:0] mode_exp; // exponent from mode register
    logic [23:0] out_meas; // measured output voltage
    pfcuv_req_t req; // requests from the host model
    logic [15:0] rd_data; // read data
    logic rd_valid; // read answer
    pfcuv_status_t st; // status flags
    logic [15:0] exp_q[$]; // expected read answers
    logic [15:0] d; // random write data
    int fails; // mismatches
    int num_checks; // comparisons
    int seed = 32'hb757e87f; // fixed random seed
    int d1; // expected first delay in cycles
    // clock at 250 MHz
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // host model drives the register port
    pfcuv_host_model i_host (.clock(clock), .req(req));
    // design under test with short millisecond
    pfcuv_limit_fault #(.MS_CYCLES(MSC)) i_dut (.clock(clock), .rstn(rstn), .req(req),
        .mode_exp(mode_exp), .out_meas(out_meas), .rd_data_reg(rd_data), .rd_valid_reg(rd_valid),
        .status_reg(st));
    // compare a read answer
    task automatic chk16(input logic [15:0] got, input logic [15:0] expv);
        num_checks++;
        if (got !== expv) begin
            fails++;
            $display("Error t=%0t read %h expected %h", $time, got, expv);
        end
    endtask : chk16
    // compare the status word
    task automatic chk5(input logic [4:0] got, input logic [4:0] expv);
        num_checks++;
        if (got !== expv) begin
            fails++;
            $display("Error t=%0t status %b expected %b", $time, got, expv);
        end
    endtask : chk5
    // compare one bit
    task automatic chk1(input logic got, input logic expv);
        num_checks++;
        if (got !== expv) begin
            fails++;
            $display("Error t=%0t flag %b expected %b", $time, got, expv);
        end
    endtask : chk1
    // note the expected answer, then issue the read
    task automatic rd(input logic [7:0] cmd, input logic [15:0] expv);
        exp_q.push_back(expv);
        i_host.read_reg(cmd);
    endtask : rd
    // wait n falling edges
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask : wait_n
    // output enable must reach val after at least lo and fewer than hi cycles
    task automatic expect_en(input logic val, input int lo, input int hi);
        int n;
        n = 0;
        while (st.out_enable !== val && n < hi) begin
            @(negedge clock);
            n++;
        end
        chk1(n >= lo && n < hi, 1'b1);
    endtask : expect_en
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // answer monitor: oldest note against each read answer
    always @(negedge clock) begin
        if (rd_valid === 1'b1) begin
            chk1(exp_q.size() > 0, 1'b1);
            if (exp_q.size() > 0) begin
                chk16(rd_data, exp_q.pop_front());
            end
        end
    end
    // watchdog cuts a hang short
    initial begin
        #80000;
        fails++;
        $display("Error t=%0t watchdog expired", $time);
        finish_test();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        mode_exp = 3'h0;
        out_meas = OK_V;
        wait_n(4);
        chk5(st, 5'b00010);
        rstn = 1'b1;
        rd(PFCUV_CMD_UV_FAULT, 16'h0000);
        rd(8'h46, 16'h0000);
        // mantissa writes under every exponent; exponent bits are not writable
        for (int e = 0; e < 8; e++) begin
            mode_exp = 3'(e);
            for (int c = 0; c < 3; c++) begin
                d = 16'($random(seed));
                i_host.write_reg(PFCUV_CMD_OV_WARN + 8'(c), d);
                rd(PFCUV_CMD_OV_WARN + 8'(c), {{2{mode_exp[2]}}, mode_exp, d[10:0]});
            end
        end
        i_host.write_reg(PFCUV_CMD_ACTION, 16'hFF00);
        rd(PFCUV_CMD_ACTION, 16'h0000);
        wait_n(3);
        $display("test registers done");
        // thresholds for warnings and fault flag; action 00 leaves output on
        i_host.write_reg(PFCUV_CMD_OV_WARN, 16'h0300);
        i_host.write_reg(PFCUV_CMD_UV_WARN, 16'h0100);
        i_host.write_reg(PFCUV_CMD_UV_FAULT, 16'h0080);
        for (int i = 0; i < 8; i++) begin
            mode_exp = WTAB[i][29:27];
            out_meas = WTAB[i][26:3];
            wait_n(3);
            chk5(st, {WTAB[i][2:0], 2'b10});
        end
        mode_exp = 3'h0;
        out_meas = OK_V;
        $display("test warnings done");
        // hold off while the fault persists
        i_host.write_reg(PFCUV_CMD_ACTION, 16'h00C0);
        out_meas = BAD_V;
        expect_en(1'b0, 0, 4);
        wait_n(20);
        chk1(st.out_enable, 1'b0);
        out_meas = OK_V;
        expect_en(1'b1, 0, 5);
        $display("test hold done");
        // shutdown and restarts with retry 0, 1 and unlimited
        for (int i = 0; i < 3; i++) begin
            i_host.write_reg(PFCUV_CMD_ACTION, {8'h00, RTAB[i]});
            out_meas = BAD_V;
            expect_en(1'b0, 0, 4);
            if (RTAB[i][5:3] != 3'h0) begin
                expect_en(1'b1, 252 * MSC - 8, 252 * MSC + 8);
                expect_en(1'b0, 10 * MSC - 2, 10 * MSC + 6);
            end
            chk1(st.latched_off, RTAB[i][5:3] != PFCUV_RETRY_INF);
            out_meas = OK_V;
            i_host.write_reg(PFCUV_CMD_ACTION, 16'h0000);
            expect_en(1'b1, 0, 1100);
            wait_n(12 * MSC); // let a pending settle delay end before the next action
            chk1(st.out_enable, 1'b1);
        end
        $display("test restart done");
        // delayed shutdown for three delay codes
        for (int c = 0; c < 3; c++) begin
            d1 = (10 * MSC) << c;
            i_host.write_reg(PFCUV_CMD_ACTION, 16'h0040 + 16'(c));
            out_meas = BAD_V;
            expect_en(1'b0, d1 - 2, d1 + 6);
            chk1(st.latched_off, 1'b1);
            out_meas = OK_V;
            i_host.write_reg(PFCUV_CMD_ACTION, 16'h0000);
            expect_en(1'b1, 0, 10);
        end
        $display("test delay done");
        chk1(exp_q.size() == 0, 1'b1);
        finish_test();
    end
endmodule : pfcuv_limit_fault_tb_top

// >>> pfcuv_ms_timer.sv
// one-shot millisecond timer used for fault delays
`timescale 1ns/100ps
module pfcuv_ms_timer
    import pfcuv_pkg::*;
#(
    parameter int MS_CYCLES = PFCUV_MS_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic start,
    input wire logic [11:0] target_ms,
    output logic done_reg
);

    logic [31:0] pre_reg; // cycles within the current ms
    logic [11:0] ms_reg; // whole ms elapsed
    logic busy_reg; // timer running

    // prescaler and ms count; a start restarts the timer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_reg <= 32'h00000000;
            ms_reg <= 12'h000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                pre_reg <= 32'h00000000;
                ms_reg <= 12'h000;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (pre_reg == 32'(MS_CYCLES - 1)) begin
                    pre_reg <= 32'h00000000;
                    ms_reg <= ms_reg + 12'h001;
                    // zero target behaves as one ms
                    if (ms_reg + 12'h001 >= target_ms) begin
                        done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                    end
                end else begin
                    pre_reg <= pre_reg + 32'h00000001;
                end
            end
        end
    end

endmodule : pfcuv_ms_timer

// >>> pfcuv_pkg.sv
// package: constants, types and helpers of the output voltage limit and undervoltage fault block
// Summary of operation
// - warn when output above overvoltage warning limit
// - warn when output below undervoltage warning limit
// - fault when output below undervoltage fault limit
// - limit top five bits mirror mode exponent
// - returned exponent is two's complement
// - writable 11-bit mantissa, threshold mantissa times 2^exp
// - bits 7:6 of action register pick reaction
// - code 01: wait first delay, then retry
// - code 10: shut down now, then retry
// - code 11: off while fault persists, then re-enable
// - first delay 10 ms doubling to 1280 ms
// - second delay spaces restarts, 252 to 2604 ms
package pfcuv_pkg;

    // command codes of the four registers
    localparam logic [7:0] PFCUV_CMD_OV_WARN = 8'h42;
    localparam logic [7:0] PFCUV_CMD_UV_WARN = 8'h43;
    localparam logic [7:0] PFCUV_CMD_UV_FAULT = 8'h44;
    localparam logic [7:0] PFCUV_CMD_ACTION = 8'h45;

    // field positions
    localparam int PFCUV_EXP_LSB = 11;
    localparam int PFCUV_MANT_W = 11;
    localparam int PFCUV_RESP_LSB = 6;
    localparam int PFCUV_RETRY_LSB = 3;
    localparam int PFCUV_DLY_LSB = 0;

    // values after reset
    localparam logic [10:0] PFCUV_OV_WARN_RST = 11'h7FF;
    localparam logic [10:0] PFCUV_UV_WARN_RST = 11'h000;
    localparam logic [10:0] PFCUV_UV_FAULT_RST = 11'h000;
    localparam logic [7:0] PFCUV_ACTION_RST = 8'h00;

    // retry code meaning unlimited restarts
    localparam logic [2:0] PFCUV_RETRY_INF = 3'h7;

    // fractional bits of the measured output voltage
    localparam logic [3:0] PFCUV_MEAS_FRAC = 4'h8;
    localparam int PFCUV_MEAS_W = 24;

    // time base: clock period and one millisecond
    localparam int PFCUV_CLK_PERIOD_PS = 4000;
    localparam int PFCUV_MS_PS = 1000000000;
    localparam int PFCUV_MS_CYCLES = PFCUV_MS_PS / PFCUV_CLK_PERIOD_PS;

    // first delay base time in ms
    localparam logic [11:0] PFCUV_DLY1_BASE_MS = 12'h00A;

    // reaction codes
    typedef enum logic [1:0] {
        PFCUV_RESP_IGNORE = 2'b00,
        PFCUV_RESP_DELAY = 2'b01,
        PFCUV_RESP_RESTART = 2'b10,
        PFCUV_RESP_HOLD = 2'b11
    } pfcuv_resp_t;

    // fault sequencer states
    typedef enum logic [2:0] {
        PFCUV_ST_RUN = 3'b000,
        PFCUV_ST_WAIT_D1 = 3'b001,
        PFCUV_ST_OFF_WAIT = 3'b010,
        PFCUV_ST_SETTLE = 3'b011,
        PFCUV_ST_HOLD = 3'b100,
        PFCUV_ST_LATCHED = 3'b101
    } pfcuv_state_t;

    // register access request from the bus engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] data;
    } pfcuv_req_t;

    // status flags shown to the rest of the chip
    typedef struct packed {
        logic ov_warn;
        logic uv_warn;
        logic uv_fault;
        logic out_enable;
        logic latched_off;
    } pfcuv_status_t;

    // first delay: 10 ms doubled per code step
    function automatic logic [11:0] pfcuv_dly1_ms(input logic [2:0] code);
        return PFCUV_DLY1_BASE_MS << code;
    endfunction : pfcuv_dly1_ms

    // second delay lookup in ms
    function automatic logic [11:0] pfcuv_dly2_ms(input logic [2:0] code);
        logic [11:0] ms;
        case (code)
            3'h0: ms = 12'h0FC;
            3'h1: ms = 12'h22E;
            3'h2: ms = 12'h39C;
            3'h3: ms = 12'h4EC;
            3'h4: ms = 12'h63C;
            3'h5: ms = 12'h78C;
            3'h6: ms = 12'h8DC;
            default: ms = 12'hA2C;
        endcase
        return ms;
    endfunction : pfcuv_dly2_ms

    // threshold = mantissa * 2^(exp+8), in measurement units
    function automatic logic [23:0] pfcuv_scale(input logic [10:0] m, input logic [2:0] e);
        logic [3:0] sh;
        sh = PFCUV_MEAS_FRAC + {e[2], e};
        return {13'h0000, m} << sh;
    endfunction : pfcuv_scale

endpackage : pfcuv_pkg
